// ---- include/i2cpk_pkg.sv ----
// i2cpk_pkg: shared constants for the two-wire register access slave and its master
package i2cpk_pkg;
  localparam logic [6:0] I2CPK_DEV_ADDR = 7'h54;
  localparam logic [7:0] I2CPK_PTR_PEAK = 8'h07;
  localparam logic [15:0] I2CPK_PEAK_RST = 16'h0000;
  localparam int I2CPK_PEAK_MSB = 11;
  localparam int I2CPK_DATA_W = 12;
  localparam logic [4:0] I2CPK_HS_CODE_HI = 5'h01;
  localparam logic [2:0] I2CPK_CYC_OFF = 3'h0;
  localparam int I2CPK_CLK_HZ = 25000000;
  localparam int I2CPK_SCL_HZ = 100000;
  localparam int I2CPK_HALF_CYC = I2CPK_CLK_HZ / (2 * I2CPK_SCL_HZ);
  // master command register map
  localparam logic [3:0] I2CPK_REG_CTRL = 4'h0;
  localparam logic [3:0] I2CPK_REG_DATA = 4'h1;
  localparam logic [3:0] I2CPK_REG_STAT = 4'h2;
  localparam logic [3:0] I2CPK_REG_RDAT = 4'h3;
  localparam logic [2:0] I2CPK_CMD_START = 3'h1;
  localparam logic [2:0] I2CPK_CMD_WRITE = 3'h2;
  localparam logic [2:0] I2CPK_CMD_READ = 3'h3;
  localparam logic [2:0] I2CPK_CMD_STOP = 3'h4;
endpackage

// ---- include/i2cpk_if.sv ----
// i2cpk_if: open-drain two-wire bus between master and slave
`timescale 1ns/10ps
interface i2cpk_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;
  // wired-and with pull-up: any enabled driver pulls low
  assign scl = !scl_oe_m;
  assign sda = !(sda_oe_m || sda_oe_s);
  modport master (output scl_o_m, scl_oe_m, sda_o_m, sda_oe_m, input scl, sda);
  modport slave (output sda_o_s, sda_oe_s, input scl, sda);
endinterface

// ---- logic/i2cpk_slave.sv ----
// i2cpk_slave: two-wire slave with register pointer and peak-hold register
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module i2cpk_slave
  import i2cpk_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = I2CPK_DEV_ADDR
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  i2cpk_if.slave bus,
  input wire logic [2:0] cycle_time,
  input wire logic conv_valid,
  input wire logic [11:0] conv_data,
  output logic [7:0] pointer,
  output logic hs_mode,
  output logic [11:0] peak
);
  // ----------------------------------------------------------------
  // pin synchronisers and condition detect
  // ----------------------------------------------------------------
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.sda};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  logic scl_q;
  logic sda_q;
  assign scl_q = scl_s_r[1];
  assign sda_q = sda_s_r[1];
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_q && !scl_d_r;
  assign scl_fall = !scl_q && scl_d_r;
  assign start_det = scl_q && scl_d_r && sda_d_r && !sda_q;
  assign stop_det = scl_q && scl_d_r && !sda_d_r && sda_q;

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK}
    i2cpk_st_t;
  i2cpk_st_t st_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [1:0] wr_idx_r; // 0 pointer, 1 upper, 2 lower
  logic rd_lo_r;
  logic [7:0] hi_byte_r;
  logic [7:0] pointer_r;
  logic sda_drv_r;
  logic hs_r;
  logic peak_wr;
  logic [15:0] peak_wdata;
  logic [11:0] peak_r;
  logic [15:0] reg_rd;

  assign reg_rd = (pointer_r == I2CPK_PTR_PEAK) ? {4'h0, peak_r} : 16'h0000;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      wr_idx_r <= 2'h0;
      rd_lo_r <= 1'b0;
      hi_byte_r <= 8'h00;
      pointer_r <= 8'h00;
      sda_drv_r <= 1'b0;
      hs_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= ST_IDLE;
      sda_drv_r <= 1'b0;
      hs_r <= 1'b0;
    end else if (start_det) begin
      st_r <= ST_ADDR; // speed flag kept
      bit_r <= 4'h0;
      sda_drv_r <= 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_q};
            bit_r <= bit_r + 4'h1;
          end
          if (scl_fall && bit_r == 4'h8) begin
            bit_r <= 4'h0;
            if (st_r == ST_ADDR) begin
              if (sh_r[7:3] == I2CPK_HS_CODE_HI) begin
                hs_r <= 1'b1; // master code, no ack
                st_r <= ST_IDLE;
              end else if (sh_r[7:1] == DEV_ADDR) begin
                sda_drv_r <= 1'b1;
                st_r <= ST_ADDR_ACK;
                wr_idx_r <= 2'h0;
                rd_lo_r <= 1'b0;
              end else begin
                st_r <= ST_IDLE; // released = nack
              end
            end else begin
              sda_drv_r <= 1'b1;
              st_r <= ST_WR_ACK;
              if (wr_idx_r == 2'h0) begin
                pointer_r <= sh_r;
              end else if (wr_idx_r == 2'h1) begin
                hi_byte_r <= sh_r;
              end
              wr_idx_r <= (wr_idx_r == 2'h2) ? 2'h1 : wr_idx_r + 2'h1;
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            if (st_r == ST_ADDR_ACK && sh_r[0]) begin
              st_r <= ST_RD;
              sh_r <= reg_rd[15:8];
              sda_drv_r <= !reg_rd[15];
              bit_r <= 4'h1;
            end else begin
              st_r <= ST_WR;
              sda_drv_r <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_r == 4'h8) begin
              sda_drv_r <= 1'b0;
              st_r <= ST_RD_ACK;
            end else begin
              sda_drv_r <= !sh_r[3'h7 - bit_r[2:0]];
              bit_r <= bit_r + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            if (sda_q) begin
              st_r <= ST_IDLE; // nack ends, await stop
            end else begin
              rd_lo_r <= !rd_lo_r;
            end
          end else if (scl_fall) begin
            st_r <= ST_RD;
            sh_r <= rd_lo_r ? reg_rd[7:0] : reg_rd[15:8];
            sda_drv_r <= !(rd_lo_r ? reg_rd[7] : reg_rd[15]);
            bit_r <= 4'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // upper byte is held until the lower arrives so the word lands whole
  assign peak_wr = st_r == ST_WR && scl_fall && bit_r == 4'h8 && wr_idx_r == 2'h2
                   && pointer_r == I2CPK_PTR_PEAK;
  assign peak_wdata = {hi_byte_r, sh_r};

  // ----------------------------------------------------------------
  // peak-hold register
  // ----------------------------------------------------------------
  logic auto_mode;
  assign auto_mode = cycle_time != I2CPK_CYC_OFF;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      peak_r <= I2CPK_PEAK_RST[11:0];
    end else if (peak_wr) begin
      peak_r <= peak_wdata[11:0];
    end else if (auto_mode && conv_valid && conv_data > peak_r) begin
      peak_r <= conv_data;
    end
  end

  assign bus.sda_o_s = 1'b0;
  assign bus.sda_oe_s = sda_drv_r;
  assign pointer = pointer_r;
  assign hs_mode = hs_r;
  assign peak = peak_r;
endmodule

// ---- logic/i2cpk_master.sv ----
// i2cpk_master: command-driven two-wire bus master
`timescale 1ns/10ps
module i2cpk_master
  import i2cpk_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  i2cpk_if.master bus,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  // ----------------------------------------------------------------
  // registers and command issue
  // ----------------------------------------------------------------
  typedef enum {MS_IDLE, MS_START, MS_BIT, MS_ACK, MS_STOP} i2cpk_ms_t;
  i2cpk_ms_t st_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [2:0] cmd_r;
  logic ack_r;
  logic last_r;
  logic [3:0] bit_r;
  logic [1:0] ph_r;
  logic [15:0] div_r;
  logic tick;
  logic scl_drv_r;
  logic sda_drv_r;
  logic [1:0] sda_s_r;
  assign tick = div_r == 16'(I2CPK_HALF_CYC / 2 - 1);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= 16'h0000;
      sda_s_r <= 2'h3;
    end else begin
      div_r <= tick ? 16'h0000 : div_r + 16'h0001;
      sda_s_r <= {sda_s_r[0], bus.sda};
    end
  end
  logic busy;
  assign busy = st_r != MS_IDLE;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        I2CPK_REG_STAT: rdata <= {6'h00, ack_r, busy};
        I2CPK_REG_RDAT: rdata <= rx_r;
        I2CPK_REG_DATA: rdata <= tx_r;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bit sequencer: four quarter phases per bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= MS_IDLE;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      cmd_r <= 3'h0;
      ack_r <= 1'b0;
      last_r <= 1'b0;
      bit_r <= 4'h0;
      ph_r <= 2'h0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end else if (st_r == MS_IDLE) begin
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      if (wr && addr == I2CPK_REG_DATA) begin
        tx_r <= wdata;
      end else if (wr && addr == I2CPK_REG_CTRL) begin
        cmd_r <= wdata[2:0];
        last_r <= wdata[3]; // nack after this read byte
        case (wdata[2:0])
          I2CPK_CMD_START: st_r <= MS_START;
          I2CPK_CMD_WRITE, I2CPK_CMD_READ: st_r <= MS_BIT;
          I2CPK_CMD_STOP: st_r <= MS_STOP;
          default: st_r <= MS_IDLE;
        endcase
      end
    end else if (tick) begin
      ph_r <= ph_r + 2'h1;
      case (st_r)
        MS_START: begin
          // release both, then pull data low with clock high, then clock low
          case (ph_r)
            2'h0: begin
              sda_drv_r <= 1'b0;
              scl_drv_r <= 1'b0;
            end
            2'h1: sda_drv_r <= 1'b1;
            2'h2: scl_drv_r <= 1'b1;
            default: st_r <= MS_IDLE;
          endcase
        end
        MS_BIT, MS_ACK: begin
          case (ph_r)
            2'h0: begin
              if (st_r == MS_ACK) begin
                sda_drv_r <= cmd_r == I2CPK_CMD_READ && !last_r;
              end else begin
                sda_drv_r <= cmd_r == I2CPK_CMD_WRITE && !tx_r[7];
              end
            end
            2'h1: scl_drv_r <= 1'b0;
            2'h2: begin
              if (st_r == MS_ACK) begin
                ack_r <= !sda_s_r[1];
              end else begin
                rx_r <= {rx_r[6:0], sda_s_r[1]};
                tx_r <= {tx_r[6:0], 1'b0};
              end
            end
            default: begin
              scl_drv_r <= 1'b1;
              if (st_r == MS_ACK) begin
                sda_drv_r <= 1'b0;
                st_r <= MS_IDLE;
              end else if (bit_r == 4'h7) begin
                st_r <= MS_ACK; // release for acknowledge on a write, drive it low on a read unless last_r
              end else begin
                bit_r <= bit_r + 4'h1;
              end
            end
          endcase
        end
        MS_STOP: begin
          case (ph_r)
            2'h0: sda_drv_r <= 1'b1;
            2'h1: scl_drv_r <= 1'b0;
            2'h2: sda_drv_r <= 1'b0;
            default: st_r <= MS_IDLE;
          endcase
        end
        default: st_r <= MS_IDLE;
      endcase
    end
  end

  assign bus.scl_o_m = 1'b0;
  assign bus.scl_oe_m = scl_drv_r;
  assign bus.sda_o_m = 1'b0;
  assign bus.sda_oe_m = sda_drv_r;
endmodule

// ---- tb/i2cpk_asserts.sv ----
// checker: wire-level properties of the two-wire bus between master and slave
`timescale 1ns/10ps
module i2cpk_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl_o_m,
  input wire logic scl_oe_m,
  input wire logic sda_o_m,
  input wire logic sda_oe_m,
  input wire logic sda_o_s,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // helper: length of one unbroken slave pull
  // ----------------------------------------
  // eight zero bits at the slowest rate fit well inside this bound
  localparam int HOLD_MAX = 2500;
  int hold_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hold_r <= 0;
    end else if (sda_oe_s) begin
      hold_r <= hold_r + 1;
    end else begin
      hold_r <= 0;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  drive_low_only_a: assert property (!sda_o_s && !sda_o_m && !scl_o_m)
    else $error("bus driven to a high level");
  start_free_a: assert property ($fell(sda) && scl |-> !sda_oe_s)
    else $error("slave holds data line at a start");
  stop_idle_a: assert property ($rose(sda) && scl && $past(scl) |-> !sda_oe_s [*8])
    else $error("slave drives after a stop");
  no_contention_a: assert property (scl && sda_oe_s |-> !sda_oe_m)
    else $error("master and slave both drive data");
  slave_low_phase_a: assert property ($changed(sda_oe_s) |-> !scl)
    else $error("slave data changed while clock high");
  pull_bound_a: assert property (hold_r < HOLD_MAX)
    else $error("slave never released data line");
  clk_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  clk_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
endmodule

// ---- tb/i2c_slave_register_access_tb_top.sv ----
// testbench: command-driven master and slave joined over the two-wire bus
`timescale 1ns/10ps
module i2c_slave_register_access_tb_top;
  import i2cpk_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] cycle_time = 3'h0;
  logic conv_valid = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic [7:0] rdata, pointer, q;
  logic [11:0] peak;
  logic hs_mode, ack;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [7:0] AW = {I2CPK_DEV_ADDR, 1'b0};
  localparam logic [7:0] AR = {I2CPK_DEV_ADDR, 1'b1};
  i2cpk_if bus_if();
  i2cpk_master i_i2cpk_master(.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus_if.master),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  i2cpk_slave i_i2cpk_slave(.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus_if.slave),
    .cycle_time(cycle_time), .conv_valid(conv_valid), .conv_data(conv_data),
    .pointer(pointer), .hs_mode(hs_mode), .peak(peak));
  i2cpk_asserts i_chk(.clk_sys(clk_sys), .arst_n(arst_n), .scl_o_m(bus_if.scl_o_m),
    .scl_oe_m(bus_if.scl_oe_m), .sda_o_m(bus_if.sda_o_m), .sda_oe_m(bus_if.sda_oe_m),
    .sda_o_s(bus_if.sda_o_s), .sda_oe_s(bus_if.sda_oe_s), .scl(bus_if.scl), .sda(bus_if.sda));
  always #20 clk_sys = ~clk_sys;
  // ----------------------------------------
  // register port and bus command tasks
  // ----------------------------------------
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // polls busy; commands written while busy would be dropped silently
  task automatic cmd(input logic [3:0] c, input logic [7:0] d);
    logic [7:0] s;
    if (c[2:0] == I2CPK_CMD_WRITE) reg_wr(I2CPK_REG_DATA, d);
    reg_wr(I2CPK_REG_CTRL, {4'h0, c});
    repeat (2) @(posedge clk_sys);
    s = 8'h01;
    for (int i = 0; i < 3000 && s[0] !== 1'b0; i++) reg_rd(I2CPK_REG_STAT, s);
    ack = s[1];
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic st();
    cmd({1'b0, I2CPK_CMD_START}, 8'h00);
  endtask
  task automatic sp();
    cmd({1'b0, I2CPK_CMD_STOP}, 8'h00);
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  task automatic wb(input logic [7:0] b, input logic e);
    cmd({1'b0, I2CPK_CMD_WRITE}, b);
    chk(16'(ack), 16'(e));
  endtask
  task automatic rb(input logic nk);
    cmd({nk, I2CPK_CMD_READ}, 8'h00);
    reg_rd(I2CPK_REG_RDAT, q);
  endtask
  // mode is set a cycle ahead of the result so the sample sees it settled
  task automatic cv(input logic [2:0] ct, input logic [11:0] v);
    @(posedge clk_sys);
    cycle_time <= ct;
    @(posedge clk_sys);
    conv_valid <= 1'b1;
    conv_data <= v;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      complete_run();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(16'(peak), I2CPK_PEAK_RST);
    chk(16'(pointer), 16'h0000);
    reg_wr(I2CPK_REG_DATA, 8'h5c);
    reg_rd(I2CPK_REG_DATA, q);
    chk(16'(q), 16'h005c);
    $display("reset test done");
    st();
    wb(AW, 1'b1);
    wb(I2CPK_PTR_PEAK, 1'b1);
    wb(8'h05, 1'b1);
    wb(8'ha3, 1'b1);
    sp();
    chk(16'(peak), 16'h05a3);
    $display("write test done");
    st();
    wb(AR, 1'b1);
    rb(1'b0);
    chk(16'(q), 16'h0005);
    rb(1'b0);
    chk(16'(q), 16'h00a3);
    rb(1'b0);
    chk(16'(q), 16'h0005);
    rb(1'b1);
    chk(16'(q), 16'h00a3);
    sp();
    $display("preset read test done");
    st();
    wb({I2CPK_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
    sp();
    chk(16'(pointer), 16'(I2CPK_PTR_PEAK));
    $display("foreign address test done");
    cv(I2CPK_CYC_OFF, 12'hfff);
    chk(16'(peak), 16'h05a3);
    cv(3'h2, 12'h100);
    chk(16'(peak), 16'h05a3);
    cv(3'h7, 12'h7ff);
    chk(16'(peak), 16'h07ff);
    $display("tracking test done");
    st();
    wb(AW, 1'b1);
    wb(I2CPK_PTR_PEAK, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h00, 1'b1);
    st();
    wb(AR, 1'b1);
    rb(1'b1);
    chk(16'(q), 16'h0000);
    sp();
    cv(3'h1, 12'h010);
    chk(16'(peak), 16'h0010);
    $display("clear test done");
    st();
    wb(8'h08, 1'b0);
    chk(16'(hs_mode), 16'h0001);
    st();
    wb(AR, 1'b1);
    chk(16'(hs_mode), 16'h0001);
    rb(1'b1);
    chk(16'(q), 16'h0000);
    sp();
    chk(16'(hs_mode), 16'h0000);
    $display("speed mode test done");
    complete_run();
  end
endmodule
